// File: inc/iosr_defines.vh
`ifndef IOSR_DEFINES_VH
`define IOSR_DEFINES_VH
// register byte offsets
`define IOSR_OFS_CTRL      8'h00
`define IOSR_OFS_IVAL      8'h04
`define IOSR_OFS_CHGMASK   8'h08
`define IOSR_OFS_DSTHI     8'h0c
`define IOSR_OFS_DSTLO     8'h10
`define IOSR_OFS_PINCFG_LO 8'h14
`define IOSR_OFS_PINCFG_HI 8'h18
`define IOSR_OFS_WAKEHOLD  8'h1c
`define IOSR_OFS_STATUS    8'h20
`define IOSR_OFS_RXSAMPLE  8'h24
// ctrl fields
`define IOSR_CTRL_QUERY    0
`define IOSR_CTRL_REMOTE   1
`define IOSR_CTRL_APIMODE  2
`define IOSR_CTRL_SLEEPDEV 3
// per-pin configuration codes
`define IOSR_PIN_UNMON     4'h0
`define IOSR_PIN_ANALOG    4'h2
`define IOSR_PIN_MONDIG    4'h3
// record constants
`define IOSR_SAMPLE_SETS   8'h01
`define IOSR_VSUPPLY_BIT   7
`define IOSR_MAX_BYTES     16
// timing
`define IOSR_CLK_HZ        125000000
`define IOSR_MS_CYCLES     (`IOSR_CLK_HZ / 1000)
// record destinations
`define IOSR_DST_HOST      2'h0
`define IOSR_DST_QUERIER   2'h1
`define IOSR_DST_REMOTE    2'h2
`endif

// File: hdl/iosr_rec_mem.v
`timescale 1ns/100ps
module iosr_rec_mem #(
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire         clk_sys_in,
	input  wire         wr_en_in,
	input  wire [AW-1:0] wr_addr_in,
	input  wire [7:0]   wr_data_in,
	input  wire [AW-1:0] rd_addr_in,
	output reg  [7:0]   rd_data_out
);
	reg [7:0] mem_ff [0:DEPTH-1];
	always @(posedge clk_sys_in) begin
		if (wr_en_in)
			mem_ff[wr_addr_in] <= wr_data_in;
		rd_data_out <= mem_ff[rd_addr_in];
	end
endmodule

// File: hdl/iosr_top.v
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "iosr_defines.vh"
// Notes on behaviour
// (RQ1) first record byte: sample set count one
// (RQ2) two-byte digital mask, bits 8,9 unused
// (RQ3) analog mask byte, bit7 supply voltage
// (RQ4) digital states present only if mask nonzero
// (RQ5) receiver ignores states outside digital mask
// (RQ6) analog readings analog_input_zero..analog_input_three then supply, enabled
// (RQ7) analog readings are 10-bit, 1.2V fullscale
// (RQ8) consumer millivolts = reading*1200/1023
// (RQ9) query samples all enabled channels once
// (RQ10) local query to host, remote back
// (RQ11) transparent mode CR-delimited, api mode framed
// (RQ12) interval zero disables, else periodic sample
// (RQ13) periodic samples go to dest address
// (RQ14) api forwards received samples, transparent drops; api mode also drops them during S_SEND
// (RQ15) sleep device samples until wake-hold expires
// (RQ16) change mask lines trigger immediate sample
// (RQ17) change samples go to dest address
// (RQ18) pin code selects analog/monitored/unmonitored sampling; unmonitored (code 0) lines still go into the digital mask
// (RQ19) multi-byte fields sent msb first
// (RQ20) state bits align with mask bits
// (RQ21) fixed field order: count, masks, data
module iosr_top #(
	parameter MS_CYCLES = `IOSR_MS_CYCLES
) (
	input  wire        clk_sys_in,
	input  wire        reset_n_in,
	input  wire        hsel_in,
	input  wire [31:0] haddr_in,
	input  wire [1:0]  htrans_in,
	input  wire        hwrite_in,
	input  wire [2:0]  hsize_in,
	input  wire [31:0] hwdata_in,
	input  wire        hready_in,
	output reg  [31:0] hrdata_out,
	output reg         hreadyout_out,
	output reg         hresp_out,
	input  wire [12:0] dio_lines_in,
	input  wire [9:0]  analog_in0_in,
	input  wire [9:0]  analog_in1_in,
	input  wire [9:0]  analog_in2_in,
	input  wire [9:0]  analog_in3_in,
	input  wire [9:0]  supply_volt_in,
	input  wire        rx_sample_valid_in,
	input  wire [7:0]  rx_sample_byte_in,
	input  wire        rx_sample_last_in,
	output reg  [7:0]  rec_byte_out,
	output reg         rec_valid_out,
	output reg         rec_first_out,
	output reg         rec_last_out,
	output reg         rec_cr_out,
	output reg         rec_api_out,
	output reg  [1:0]  rec_dest_out,
	output reg  [63:0] rec_addr_out,
	output reg         rec_fwd_out,
	output reg         awake_hold_out
);
	localparam S_IDLE = 4'h1;
	localparam S_LOAD = 4'h2;
	localparam S_SEND = 4'h4;
	localparam S_WAIT = 4'h8;

	reg  [3:0]  ctrl_ff;
	reg  [15:0] ival_ff;
	reg  [12:0] chg_mask_ff;
	reg  [31:0] dst_hi_ff;
	reg  [31:0] dst_lo_ff;
	reg  [31:0] pincfg_lo_ff;
	reg  [31:0] pincfg_hi_ff;
	reg  [15:0] wake_ms_ff;
	reg  [7:0]  status_ff;
	reg         ap_wr_ff;
	reg         ap_rd_ff;
	reg  [7:0]  ap_addr_ff;
	reg  [3:0]  state_ff;
	reg  [1:0]  pend_ff;
	reg  [1:0]  dest_ff;
	reg  [3:0]  wr_ptr_ff;
	reg  [3:0]  len_ff;
	reg  [3:0]  rd_ptr_ff;
	reg  [12:0] dio_prev_ff;
	reg  [31:0] ms_cnt_ff;
	reg  [15:0] ival_cnt_ff;
	reg  [15:0] wake_cnt_ff;
	reg         query_req_ff;
	reg         query_remote_ff;
	reg  [7:0]  rx_fwd_cnt_ff;
	reg  [7:0]  rec_bytes [0:`IOSR_MAX_BYTES-1];
	wire [7:0]  mem_rd;
	reg  [12:0] dmask;
	reg  [7:0]  amask;
	reg  [3:0]  nlen;
	reg  [3:0]  k;
	integer     i;
	integer     j;

	wire        ap_take = hsel_in & hready_in & htrans_in[1];
	wire        ms_tick = (ms_cnt_ff == MS_CYCLES - 1);
	wire [12:0] chg_hit = (dio_lines_in ^ dio_prev_ff) & chg_mask_ff;
	wire [63:0] dst_addr = {dst_hi_ff, dst_lo_ff};
	wire [63:0] pin_cfg  = {pincfg_hi_ff, pincfg_lo_ff};
	wire [39:0] ain_all  = {analog_in3_in, analog_in2_in, analog_in1_in, analog_in0_in};

	// configuration passed in so the mask logic wakes on every pin code write
	function [3:0] pin_code;
		input [63:0] cfg;
		input [3:0]  idx;
		pin_code = cfg[idx*4 +: 4];
	endfunction

	// masks built from pin codes, lines 8 and 9 never sampled
	always @* begin
		dmask = 13'h0000;
		amask = 8'h00;
		for (i = 0; i < 13; i = i + 1) begin
			if (i != 8 && i != 9 &&
			    (pin_code(pin_cfg, i[3:0]) == `IOSR_PIN_MONDIG ||
			     pin_code(pin_cfg, i[3:0]) == `IOSR_PIN_UNMON)) // RQ18 RQ2
				dmask[i] = 1'b1;
		end
		for (i = 0; i < 4; i = i + 1) begin
			if (pin_code(pin_cfg, i[3:0]) == `IOSR_PIN_ANALOG) // RQ18 RQ3
				amask[i] = 1'b1;
		end
		amask[`IOSR_VSUPPLY_BIT] = ctrl_ff[`IOSR_CTRL_SLEEPDEV] | 1'b1;
	end

	// record assembly into byte array, msb first
	always @* begin
		for (j = 0; j < `IOSR_MAX_BYTES; j = j + 1)
			rec_bytes[j] = 8'h00;
		rec_bytes[0] = `IOSR_SAMPLE_SETS; // RQ1 RQ21
		rec_bytes[1] = {3'h0, dmask[12:8]}; // RQ2 RQ19
		rec_bytes[2] = dmask[7:0];
		rec_bytes[3] = amask; // RQ3
		k = 4'h4;
		if (dmask != 13'h0000) begin // RQ4
			rec_bytes[k] = {3'h0, dio_lines_in[12:8] & dmask[12:8]}; // RQ20
			rec_bytes[k+4'h1] = dio_lines_in[7:0] & dmask[7:0];
			k = k + 4'h2;
		end
		for (j = 0; j < 4; j = j + 1) begin
			if (amask[j]) begin // RQ6 RQ7
				rec_bytes[k] = {6'h00, ain_all[j*10+8 +: 2]};
				rec_bytes[k+4'h1] = ain_all[j*10 +: 8];
				k = k + 4'h2;
			end
		end
		rec_bytes[k] = {6'h00, supply_volt_in[9:8]};
		rec_bytes[k+4'h1] = supply_volt_in[7:0];
		nlen = k + 4'h1;
	end

	iosr_rec_mem #(
		.DEPTH (`IOSR_MAX_BYTES),
		.AW    (4)
	) u_mem (
		.clk_sys_in  (clk_sys_in),
		.wr_en_in    (state_ff == S_LOAD),
		.wr_addr_in  (wr_ptr_ff),
		.wr_data_in  (rec_bytes[wr_ptr_ff]),
		.rd_addr_in  (rd_ptr_ff),
		.rd_data_out (mem_rd)
	);

	// ahb-lite slave; reads take one wait state so a write just landed is seen
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ap_wr_ff      <= 1'b0;
			ap_rd_ff      <= 1'b0;
			ap_addr_ff    <= 8'h00;
			hrdata_out    <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			ctrl_ff       <= 4'h0;
			ival_ff       <= 16'h0000;
			chg_mask_ff   <= 13'h0000;
			dst_hi_ff     <= 32'h00000000;
			dst_lo_ff     <= 32'h00000000;
			pincfg_lo_ff  <= 32'h00000000;
			pincfg_hi_ff  <= 32'h00000000;
			wake_ms_ff    <= 16'h0000;
			query_req_ff  <= 1'b0;
			query_remote_ff <= 1'b0;
		end else begin
			ap_wr_ff   <= ap_take & hwrite_in;
			ap_rd_ff   <= ap_take & ~hwrite_in;
			ap_addr_ff <= haddr_in[7:0];
			hreadyout_out <= ~(ap_take & ~hwrite_in);
			if (state_ff == S_IDLE && query_req_ff)
				query_req_ff <= 1'b0;
			if (ap_rd_ff) begin
				case (ap_addr_ff)
				`IOSR_OFS_CTRL:      hrdata_out <= {28'h0000000, ctrl_ff};
				`IOSR_OFS_IVAL:      hrdata_out <= {16'h0000, ival_ff};
				`IOSR_OFS_CHGMASK:   hrdata_out <= {19'h00000, chg_mask_ff};
				`IOSR_OFS_DSTHI:     hrdata_out <= dst_hi_ff;
				`IOSR_OFS_DSTLO:     hrdata_out <= dst_lo_ff;
				`IOSR_OFS_PINCFG_LO: hrdata_out <= pincfg_lo_ff;
				`IOSR_OFS_PINCFG_HI: hrdata_out <= pincfg_hi_ff;
				`IOSR_OFS_WAKEHOLD:  hrdata_out <= {16'h0000, wake_ms_ff};
				`IOSR_OFS_STATUS:    hrdata_out <= {24'h000000, status_ff};
				`IOSR_OFS_RXSAMPLE:  hrdata_out <= {24'h000000, rx_fwd_cnt_ff};
				default:             hrdata_out <= 32'h00000000;
				endcase
			end
			if (ap_wr_ff) begin
				case (ap_addr_ff)
				`IOSR_OFS_CTRL: begin
					ctrl_ff <= {hwdata_in[3:1], 1'b0};
					if (hwdata_in[`IOSR_CTRL_QUERY]) begin // RQ9
						query_req_ff    <= 1'b1;
						query_remote_ff <= hwdata_in[`IOSR_CTRL_REMOTE];
					end
				end
				`IOSR_OFS_IVAL:      ival_ff <= hwdata_in[15:0];
				`IOSR_OFS_CHGMASK:   chg_mask_ff <= hwdata_in[12:0];
				`IOSR_OFS_DSTHI:     dst_hi_ff <= hwdata_in;
				`IOSR_OFS_DSTLO:     dst_lo_ff <= hwdata_in;
				`IOSR_OFS_PINCFG_LO: pincfg_lo_ff <= hwdata_in;
				`IOSR_OFS_PINCFG_HI: pincfg_hi_ff <= hwdata_in;
				`IOSR_OFS_WAKEHOLD:  wake_ms_ff <= hwdata_in[15:0];
				default: ;
				endcase
			end
		end
	end

	// timers, triggers and record sequencer
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff       <= S_IDLE;
			pend_ff        <= 2'h0;
			dest_ff        <= 2'h0;
			wr_ptr_ff      <= 4'h0;
			rd_ptr_ff      <= 4'h0;
			len_ff         <= 4'h0;
			dio_prev_ff    <= 13'h0000;
			ms_cnt_ff      <= 32'h00000000;
			ival_cnt_ff    <= 16'h0000;
			wake_cnt_ff    <= 16'h0000;
			status_ff      <= 8'h00;
			rx_fwd_cnt_ff  <= 8'h00;
			rec_byte_out   <= 8'h00;
			rec_valid_out  <= 1'b0;
			rec_first_out  <= 1'b0;
			rec_last_out   <= 1'b0;
			rec_cr_out     <= 1'b0;
			rec_api_out    <= 1'b0;
			rec_dest_out   <= 2'h0;
			rec_addr_out   <= 64'h0000000000000000;
			rec_fwd_out    <= 1'b0;
			awake_hold_out <= 1'b0;
		end else begin
			dio_prev_ff <= dio_lines_in;
			ms_cnt_ff   <= ms_tick ? 32'h00000000 : ms_cnt_ff + 32'h00000001;
			// periodic interval in ms; zero disables
			if (ival_ff == 16'h0000) // RQ12
				ival_cnt_ff <= 16'h0000;
			else if (ms_tick)
				ival_cnt_ff <= (ival_cnt_ff + 16'h0001 >= ival_ff) ? 16'h0000 : ival_cnt_ff + 16'h0001;
			// wake-hold window keeps a sleeping device sampling
			if (!ctrl_ff[`IOSR_CTRL_SLEEPDEV]) begin
				wake_cnt_ff    <= wake_ms_ff;
				awake_hold_out <= 1'b0;
			end else if (ms_tick && wake_cnt_ff != 16'h0000) begin
				wake_cnt_ff    <= wake_cnt_ff - 16'h0001;
			end
			if (ctrl_ff[`IOSR_CTRL_SLEEPDEV])
				awake_hold_out <= (wake_cnt_ff != 16'h0000); // RQ15
			// received samples forwarded in api mode outside S_SEND, else dropped
			rec_fwd_out <= 1'b0;
			if (rx_sample_valid_in && state_ff != S_SEND) begin
				if (ctrl_ff[`IOSR_CTRL_APIMODE]) begin // RQ14
					rec_fwd_out   <= 1'b1;
					rec_byte_out  <= rx_sample_byte_in;
					rec_dest_out  <= `IOSR_DST_HOST;
					if (rx_sample_last_in)
						rx_fwd_cnt_ff <= rx_fwd_cnt_ff + 8'h01;
				end
			end
			rec_api_out   <= ctrl_ff[`IOSR_CTRL_APIMODE];
			rec_valid_out <= 1'b0;
			rec_first_out <= 1'b0;
			rec_last_out  <= 1'b0;
			status_ff <= {4'h0, state_ff};
			case (state_ff)
			S_IDLE: begin
				wr_ptr_ff <= 4'h0;
				if (query_req_ff) begin
					dest_ff   <= query_remote_ff ? `IOSR_DST_QUERIER : `IOSR_DST_HOST; // RQ10
					state_ff  <= S_LOAD;
				end else if (pend_ff[0] || (pend_ff[1] &&
				             (!ctrl_ff[`IOSR_CTRL_SLEEPDEV] || wake_cnt_ff != 16'h0000))) begin
					dest_ff   <= `IOSR_DST_REMOTE; // RQ13 RQ17
					pend_ff   <= 2'h0;
					state_ff  <= S_LOAD;
				end else if (pend_ff[1]) begin
					pend_ff[1] <= 1'b0;
				end
			end
			S_LOAD: begin
				// length latched with byte 0; inputs must hold while loading
				if (wr_ptr_ff == 4'h0)
					len_ff <= nlen;
				wr_ptr_ff <= wr_ptr_ff + 4'h1;
				if (wr_ptr_ff == `IOSR_MAX_BYTES - 1) begin
					rd_ptr_ff <= 4'h0;
					state_ff  <= S_WAIT;
				end
			end
			S_WAIT: begin
				rd_ptr_ff <= 4'h1;
				state_ff  <= S_SEND;
			end
			S_SEND: begin
				rec_valid_out <= 1'b1;
				rec_byte_out  <= mem_rd;
				rec_first_out <= (rd_ptr_ff == 4'h1);
				rec_last_out  <= (rd_ptr_ff - 4'h1 == len_ff);
				rec_cr_out    <= ~ctrl_ff[`IOSR_CTRL_APIMODE] && dest_ff == `IOSR_DST_HOST; // RQ11
				rec_dest_out  <= dest_ff;
				rec_addr_out  <= dst_addr; // RQ13
				if (rd_ptr_ff - 4'h1 == len_ff)
					state_ff <= S_IDLE;
				else
					rd_ptr_ff <= rd_ptr_ff + 4'h1;
			end
			default: state_ff <= S_IDLE;
			endcase
			// trigger sets follow the case so a new event beats the clear
			if (ms_tick && ival_ff != 16'h0000 && ival_cnt_ff + 16'h0001 >= ival_ff)
				pend_ff[1] <= 1'b1;
			if (chg_hit != 13'h0000) // RQ16
				pend_ff[0] <= 1'b1;
		end
	end
endmodule

// File: testbench/iosr_top_sva.sv
`timescale 1ns/100ps
module iosr_top_sva (
	input wire       clk_sys_in,
	input wire       reset_n_in,
	input wire       hreadyout_out,
	input wire       hresp_out,
	input wire [7:0] rec_byte_out,
	input wire       rec_valid_out,
	input wire       rec_first_out,
	input wire       rec_last_out,
	input wire       rec_cr_out,
	input wire       rec_api_out,
	input wire [1:0] rec_dest_out,
	input wire       rec_fwd_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	wire st = rec_valid_out && rec_first_out && !rec_fwd_out;
	AST_BUS_OKAY: assert property (!hresp_out) else $error("bus answer not okay");
	AST_BUS_WAIT: assert property (!hreadyout_out |=> hreadyout_out) else $error("wait state too long");
	AST_SET_COUNT: assert property (st |-> rec_byte_out == 8'h01) else $error("bad set count");
	AST_HEAD: assert property (st |=> (rec_valid_out && !rec_last_out)[*4] ##1 rec_valid_out)
		else $error("record head broken");
	AST_DMASK: assert property (st |=> rec_byte_out[7:5] == 3'h0 && rec_byte_out[1:0] == 2'h0)
		else $error("unused digital mask bits set");
	AST_AMASK: assert property (st |-> ##3 rec_byte_out[6:4] == 3'h0) else $error("bad analog mask");
	AST_NO_DIG: assert property (st ##1 rec_byte_out == 8'h00 ##1 rec_byte_out == 8'h00
		|=> ##1 rec_byte_out[7:2] == 6'h00) else $error("states not omitted");
	AST_CONTIG: assert property (rec_valid_out && !rec_last_out && !rec_fwd_out |=> rec_valid_out)
		else $error("record bytes not contiguous");
	AST_FWD_API: assert property (rec_fwd_out |-> rec_api_out) else $error("forward outside api mode");
	AST_FORMAT: assert property (st && rec_dest_out == 2'h0 |-> rec_cr_out != rec_api_out)
		else $error("host format unclear");
endmodule
bind iosr_top iosr_top_sva i_sva (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .rec_byte_out(rec_byte_out), .rec_valid_out(rec_valid_out), .rec_first_out(rec_first_out),
	.rec_last_out(rec_last_out), .rec_cr_out(rec_cr_out), .rec_api_out(rec_api_out), .rec_dest_out(rec_dest_out),
	.rec_fwd_out(rec_fwd_out));

// File: testbench/iosr_far_end.sv
`timescale 1ns/100ps
module iosr_far_end (
	input  wire         clk_sys_in,
	input  wire  [7:0]  rec_byte_in,
	input  wire         rec_valid_in,
	input  wire         rec_first_in,
	input  wire         rec_fwd_in,
	input  wire  [67:0] rec_info_in,
	output logic        rx_valid_out,
	output logic [7:0]  rx_byte_out,
	output logic        rx_last_out
);
	logic [7:0]  rec_q[$];
	logic [7:0]  fwd_q[$];
	logic [67:0] info;
	int          rec_cnt = 0;
	time         rec_t;
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h5a;
		rx_last_out = 1'b0;
	end
	function automatic [15:0] live_states(input [15:0] mask, input [15:0] states);
		return mask & states;
	endfunction
	function automatic int to_mv(input [9:0] reading);
		return reading * 1200 / 1023;
	endfunction
	always @(posedge clk_sys_in) begin
		if (rec_fwd_in) begin
			fwd_q.push_back(rec_byte_in);
		end else if (rec_valid_in) begin
			if (rec_first_in) begin
				rec_cnt++;
				rec_t = $time;
				info = rec_info_in;
			end
			rec_q.push_back(rec_byte_in);
		end
	end
	task automatic send_rx(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_in);
			rx_valid_out <= 1'b1;
			rx_byte_out <= 8'ha0 + i[7:0];
			rx_last_out <= (i == n - 1);
		end
		@(posedge clk_sys_in);
		rx_valid_out <= 1'b0;
		rx_last_out <= 1'b0;
		// released byte lane shows no stale value
		rx_byte_out <= ~rx_byte_out;
	endtask
endmodule

// File: testbench/iosr_top_tb_top.sv
`timescale 1ns/100ps
`include "iosr_defines.vh"
module iosr_top_tb_top;
	logic        clk_sys_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [12:0] dio;
	wire  [31:0] hrdata;
	wire         hready, rec_valid, rec_first, rec_last, rec_cr, rec_api, rec_fwd, rx_valid, rx_last;
	wire         hresp, awake;
	wire  [7:0]  rec_byte, rx_byte;
	logic [9:0]  analog_input_zero = 10'h3d0, ain1 = 10'h124, ain2 = 10'h2c1, analog_input_three = 10'h155, vsup = 10'h2aa;
	wire  [1:0]  rec_dest;
	wire  [63:0] rec_addr;
	int          fails = 0;
	int          check_count = 0;
	int          cyc = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	iosr_top #(.MS_CYCLES(10)) i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .dio_lines_in(dio),
		.analog_in0_in(analog_input_zero), .analog_in1_in(ain1), .analog_in2_in(ain2), .analog_in3_in(analog_input_three),
		.supply_volt_in(vsup), .rx_sample_valid_in(rx_valid), .rx_sample_byte_in(rx_byte),
		.rx_sample_last_in(rx_last), .rec_byte_out(rec_byte), .rec_valid_out(rec_valid), .rec_first_out(rec_first),
		.rec_last_out(rec_last), .rec_cr_out(rec_cr), .rec_api_out(rec_api), .rec_dest_out(rec_dest),
		.rec_addr_out(rec_addr), .rec_fwd_out(rec_fwd), .awake_hold_out(awake));
	iosr_far_end i_far (.clk_sys_in(clk_sys_in), .rec_byte_in(rec_byte), .rec_valid_in(rec_valid),
		.rec_first_in(rec_first), .rec_fwd_in(rec_fwd), .rec_info_in({rec_cr, rec_api, rec_dest, rec_addr}),
		.rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .rx_last_out(rx_last));
	task automatic complete_run;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic compare(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys_in);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic wait_rec(input int n);
		int k;
		k = 0;
		while (i_far.rec_cnt < n && k < 3000) begin
			@(posedge clk_sys_in);
			k++;
		end
		repeat (20) @(posedge clk_sys_in);
		compare(i_far.rec_cnt, n);
	endtask
	task automatic check_rec(input int n, input logic [127:0] e);
		compare(i_far.rec_q.size(), n);
		foreach (i_far.rec_q[i]) compare(i_far.rec_q[i], e[8*(n-1-i) +: 8]);
		i_far.rec_q.delete();
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		logic [31:0] r;
		time         t;
		int          n;
		{hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
		dio = 13'h0408;
		repeat (8) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		wr(`IOSR_OFS_PINCFG_LO, 32'h4444_3022);
		wr(`IOSR_OFS_PINCFG_HI, 32'h0004_4300);
		bus(1'b0, `IOSR_OFS_PINCFG_LO, 32'h0, r);
		compare(r, 32'h4444_3022);
		wr(8'h40, 32'hffff_ffff);
		bus(1'b0, 8'h40, 32'h0, r);
		compare(r, 32'h0);
		compare(hresp, 1'b0);
		wr(`IOSR_OFS_CTRL, 32'h1);
		wait_rec(1);
		check_rec(12, 96'h01_040c_83_0408_03d0_0124_02aa);
		compare(i_far.info[67:64], 4'h8);
		compare(i_far.live_states(16'h040c, 16'h1c0b), 16'h0408);
		compare(i_far.to_mv(10'h3ff), 1200);
		wr(`IOSR_OFS_PINCFG_LO, 32'h4444_2242);
		wr(`IOSR_OFS_PINCFG_HI, 32'h0004_4444);
		wr(`IOSR_OFS_CTRL, 32'h3);
		wait_rec(2);
		check_rec(12, 96'h01_0000_8d_03d0_02c1_0155_02aa);
		compare(i_far.info[65:64], 2'h1);
		wr(`IOSR_OFS_CTRL, 32'h5);
		wait_rec(3);
		check_rec(12, 96'h01_0000_8d_03d0_02c1_0155_02aa);
		compare(i_far.info[67:64], 4'h4);
		i_far.send_rx(3);
		repeat (20) @(posedge clk_sys_in);
		compare({i_far.fwd_q.size(), i_far.fwd_q[0], i_far.fwd_q[2]}, {32'h3, 16'ha0a2});
		wr(`IOSR_OFS_CTRL, 32'h0);
		i_far.send_rx(2);
		repeat (20) @(posedge clk_sys_in);
		compare(i_far.fwd_q.size(), 3);
		wr(`IOSR_OFS_DSTHI, 32'h1234_5678);
		wr(`IOSR_OFS_DSTLO, 32'h9abc_def0);
		wr(`IOSR_OFS_IVAL, 32'h0000_000a);
		wait_rec(4);
		t = i_far.rec_t;
		compare(i_far.info[65:0], {2'h2, 64'h1234_5678_9abc_def0});
		wait_rec(5);
		compare(i_far.rec_t - t, 800);
		wr(`IOSR_OFS_IVAL, 32'h0);
		wr(`IOSR_OFS_DSTHI, 32'h0);
		wr(`IOSR_OFS_DSTLO, 32'h0);
		repeat (40) @(posedge clk_sys_in);
		n = i_far.rec_cnt;
		repeat (300) @(posedge clk_sys_in);
		compare(i_far.rec_cnt, n);
		dio <= 13'h0400;
		wr(`IOSR_OFS_CHGMASK, 32'h0400);
		wr(`IOSR_OFS_PINCFG_HI, 32'h0004_4344);
		repeat (40) @(posedge clk_sys_in);
		i_far.rec_q.delete();
		n = i_far.rec_cnt;
		dio <= 13'h1400;
		repeat (5) @(posedge clk_sys_in);
		dio <= 13'h0400;
		repeat (100) @(posedge clk_sys_in);
		compare(i_far.rec_cnt, n);
		dio <= 13'h0000;
		vsup <= 10'h3ff;
		wait_rec(n + 1);
		check_rec(14, 112'h01_0400_8d_0000_03d0_02c1_0155_03ff);
		compare(i_far.info[65:0], {2'h2, 64'h0});
		wr(`IOSR_OFS_WAKEHOLD, 32'h0000_0019);
		wr(`IOSR_OFS_IVAL, 32'h0000_000a);
		n = i_far.rec_cnt;
		wr(`IOSR_OFS_CTRL, 32'h8);
		repeat (2) @(posedge clk_sys_in);
		compare(awake, 1'b1);
		repeat (500) @(posedge clk_sys_in);
		compare(i_far.rec_cnt, n + 2);
		compare(awake, 1'b0);
		complete_run;
	end
endmodule
